// ---- shared/grcr_pkg.sv ----
package grcr_pkg;

    // Register indices; the bus byte address is four times the index.
    localparam logic [7:0] NEG_PUMP_LEVEL_IDX          = 8'h07;
    localparam logic [7:0] NEG_PUMP_SOFTSTART_TIME_IDX = 8'h08;
    localparam logic [7:0] NEG_PUMP_START_DELAY_IDX    = 8'h09;
    localparam logic [7:0] GATE_HIGH_BOOST_LEVEL_IDX   = 8'h0A;

    // Field layout: every register keeps a four-bit field in bits 3..0.
    localparam int FIELD_LSB   = 0;
    localparam int FIELD_WIDTH = 4;

    // Reset values of the fields.
    localparam logic [3:0] NEG_PUMP_LEVEL_RST          = 4'h1;
    localparam logic [3:0] NEG_PUMP_SOFTSTART_TIME_RST = 4'h1;
    localparam logic [3:0] NEG_PUMP_START_DELAY_RST    = 4'h1;
    localparam logic [3:0] GATE_HIGH_BOOST_LEVEL_RST   = 4'h4;

    // AXI4-Lite responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing.
    localparam int CLK_PERIOD_NS      = 25;
    localparam int STEP_TIME_NS       = 5000000;
    localparam int SS_BASE_TIME_NS    = 256000;
    localparam int STEP_CYCLES        = STEP_TIME_NS / CLK_PERIOD_NS;
    localparam int SS_BASE_CYCLES     = (SS_BASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_WIDTH        = 24;

    typedef struct packed {
        logic [3:0] neg_pump_level;
        logic [3:0] neg_pump_softstart_time;
        logic [3:0] neg_pump_start_delay;
        logic [3:0] gate_high_boost_level;
    } grcr_rail_cfg_t;

    typedef enum logic [1:0] {
        GRCR_T_IDLE = 2'b00,
        GRCR_T_RUN  = 2'b01,
        GRCR_T_DONE = 2'b11
    } grcr_timer_state_t;

endpackage

// ---- src/grcr_regs.sv ----
`timescale 1ns/100ps
module grcr_regs #(
    parameter int STEP_CYCLES    = grcr_pkg::STEP_CYCLES,
    parameter int SS_BASE_CYCLES = grcr_pkg::SS_BASE_CYCLES
) (
    // Clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // AXI4-Lite write address and data
    input  wire logic [7:0]               s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]               s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // Sequencing
    input  wire logic                     panel_reset_pin,
    input  wire logic [3:0]               source_boost_delay_code,
    output logic                          source_boost_rail_en,
    output logic                          neg_pump_en,
    output logic                          neg_pump_softstart_done,
    // Stored settings for the analog converters
    output grcr_pkg::grcr_rail_cfg_t      rail_cfg
);

    // Returns 1..4 for a mapped register, 0 for an unmapped byte address.
    function automatic logic [2:0] grcr_sel(input logic [7:0] addr);
        logic [7:0] idx;
        idx = {2'h0, addr[7:2]};
        grcr_sel = 3'h0;
        if (addr[1:0] == 2'h0) begin
            if (idx == grcr_pkg::NEG_PUMP_LEVEL_IDX)          grcr_sel = 3'h1;
            if (idx == grcr_pkg::NEG_PUMP_SOFTSTART_TIME_IDX) grcr_sel = 3'h2;
            if (idx == grcr_pkg::NEG_PUMP_START_DELAY_IDX)    grcr_sel = 3'h3;
            if (idx == grcr_pkg::GATE_HIGH_BOOST_LEVEL_IDX)   grcr_sel = 3'h4;
        end
    endfunction

    logic [7:0]                  aw_addr_reg;
    logic                        aw_hold_reg;
    logic [31:0]                 w_data_reg;
    logic                        w_strb0_reg;
    logic                        w_hold_reg;
    logic                        bvalid_reg;
    logic [1:0]                  bresp_reg;
    logic                        rvalid_reg;
    logic [1:0]                  rresp_reg;
    logic [31:0]                 rdata_reg;
    grcr_pkg::grcr_rail_cfg_t    cfg_reg;
    logic                        wr_fire;
    logic [2:0]                  wr_sel;
    logic                        wr_take;
    logic [3:0]                  wr_field;

    assign s_axi_awready = !aw_hold_reg;
    assign s_axi_wready  = !w_hold_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign rail_cfg      = cfg_reg;

    assign wr_fire  = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign wr_sel   = grcr_sel(aw_addr_reg);
    assign wr_take  = wr_fire && (wr_sel != 3'h0) && w_strb0_reg;
    assign wr_field = w_data_reg[grcr_pkg::FIELD_LSB +: grcr_pkg::FIELD_WIDTH];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid && !aw_hold_reg) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_reg  <= 1'b0;
            w_data_reg  <= 32'h0000_0000;
            w_strb0_reg <= 1'b0;
        end else if (s_axi_wvalid && !w_hold_reg) begin
            w_hold_reg  <= 1'b1;
            w_data_reg  <= s_axi_wdata;
            w_strb0_reg <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= grcr_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wr_sel == 3'h0) ? grcr_pkg::RESP_SLVERR : grcr_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // A write with byte lane 0 disabled is acknowledged but changes nothing.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_reg.neg_pump_level          <= grcr_pkg::NEG_PUMP_LEVEL_RST;
            cfg_reg.neg_pump_softstart_time <= grcr_pkg::NEG_PUMP_SOFTSTART_TIME_RST;
            cfg_reg.neg_pump_start_delay    <= grcr_pkg::NEG_PUMP_START_DELAY_RST;
            cfg_reg.gate_high_boost_level   <= grcr_pkg::GATE_HIGH_BOOST_LEVEL_RST;
        end else if (wr_take) begin
            unique case (wr_sel)
                3'h1:    cfg_reg.neg_pump_level          <= wr_field;
                3'h2:    cfg_reg.neg_pump_softstart_time <= wr_field;
                3'h3:    cfg_reg.neg_pump_start_delay    <= wr_field;
                default: cfg_reg.gate_high_boost_level   <= wr_field;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= grcr_pkg::RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= grcr_pkg::RESP_OKAY;
            unique case (grcr_sel(s_axi_araddr))
                3'h1:    rdata_reg <= {28'h0000000, cfg_reg.neg_pump_level};
                3'h2:    rdata_reg <= {28'h0000000, cfg_reg.neg_pump_softstart_time};
                3'h3:    rdata_reg <= {28'h0000000, cfg_reg.neg_pump_start_delay};
                3'h4:    rdata_reg <= {28'h0000000, cfg_reg.gate_high_boost_level};
                default: begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= grcr_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Power sequencing: panel reset rise, source rail delay, pump delay, soft-start.
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rst_prev_reg;
    logic rst_rise;
    logic src_pulse;
    logic src_done;
    logic neg_pulse;
    logic neg_done;
    logic ss_done;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
            rst_prev_reg <= 1'b0;
        end else begin
            rst_meta_reg <= panel_reset_pin;
            rst_sync_reg <= rst_meta_reg;
            rst_prev_reg <= rst_sync_reg;
        end
    end

    assign rst_rise = rst_sync_reg && !rst_prev_reg;

    // Holding the panel reset low aborts every stage, so rails drop together.
    grcr_step_timer u_src_timer (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .start       (rst_rise),
        .abort       (!rst_sync_reg),
        .code        (source_boost_delay_code),
        .unit_cycles (grcr_pkg::TIMER_WIDTH'(STEP_CYCLES)),
        .base_cycles ('0),
        .done_pulse  (src_pulse),
        .done        (src_done)
    );

    grcr_step_timer u_neg_timer (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .start       (src_pulse),
        .abort       (!rst_sync_reg),
        .code        (cfg_reg.neg_pump_start_delay),
        .unit_cycles (grcr_pkg::TIMER_WIDTH'(STEP_CYCLES)),
        .base_cycles ('0),
        .done_pulse  (neg_pulse),
        .done        (neg_done)
    );

    grcr_step_timer u_ss_timer (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .start       (neg_pulse),
        .abort       (!rst_sync_reg),
        .code        (cfg_reg.neg_pump_softstart_time),
        .unit_cycles (grcr_pkg::TIMER_WIDTH'(STEP_CYCLES)),
        .base_cycles (grcr_pkg::TIMER_WIDTH'(SS_BASE_CYCLES)),
        .done_pulse  (),
        .done        (ss_done)
    );

    assign source_boost_rail_en    = src_done;
    assign neg_pump_en             = neg_done;
    assign neg_pump_softstart_done = ss_done;

    a_read_high_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> (s_axi_rdata[31:4] == 28'h0000000))
        else $error("upper read bits not zero");
    a_level_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_take && wr_sel == 3'h1) |=> (rail_cfg.neg_pump_level == $past(w_data_reg[3:0])))
        else $error("pump level write lost");
    a_softstart_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_take && wr_sel == 3'h2)
            |=> (rail_cfg.neg_pump_softstart_time == $past(w_data_reg[3:0])))
        else $error("soft-start write lost");
    a_delay_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_take && wr_sel == 3'h3) |=> (rail_cfg.neg_pump_start_delay == $past(w_data_reg[3:0])))
        else $error("start delay write lost");
    a_gate_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_take && wr_sel == 3'h4)
            |=> (rail_cfg.gate_high_boost_level == $past(w_data_reg[3:0])))
        else $error("gate level write lost");
    a_cfg_steady: assert property (@(posedge aclk) disable iff (!aresetn)
        !wr_take |=> $stable(rail_cfg))
        else $error("setting changed without a write");
    a_pump_after_src: assert property (@(posedge aclk) disable iff (!aresetn)
        neg_pump_en |-> source_boost_rail_en)
        else $error("pump started before source rail");
    a_src_from_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(source_boost_rail_en) |-> $past(rst_sync_reg, 2))
        else $error("source rail started without panel reset high");
    a_unmapped_err: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_sel == 3'h0) |=> (s_axi_bvalid && s_axi_bresp == grcr_pkg::RESP_SLVERR))
        else $error("unmapped write not refused");

endmodule // grcr_regs

// ---- src/grcr_step_timer.sv ----
`timescale 1ns/100ps
module grcr_step_timer (
    // Clock and reset
    input  wire logic                                 aclk,
    input  wire logic                                 aresetn,
    // Control
    input  wire logic                                 start,
    input  wire logic                                 abort,
    input  wire logic [3:0]                           code,
    input  wire logic [grcr_pkg::TIMER_WIDTH-1:0]     unit_cycles,
    input  wire logic [grcr_pkg::TIMER_WIDTH-1:0]     base_cycles,
    // Status
    output logic                                      done_pulse,
    output logic                                      done
);

    function automatic logic [grcr_pkg::TIMER_WIDTH-1:0] grcr_span(
        input logic [3:0]                       c,
        input logic [grcr_pkg::TIMER_WIDTH-1:0] unit,
        input logic [grcr_pkg::TIMER_WIDTH-1:0] base);
        logic [grcr_pkg::TIMER_WIDTH+3:0] prod;
        prod = c * unit;
        grcr_span = (c == 4'h0) ? base : prod[grcr_pkg::TIMER_WIDTH-1:0];
    endfunction

    grcr_pkg::grcr_timer_state_t        state_reg;
    logic [grcr_pkg::TIMER_WIDTH-1:0]   cnt_reg;

    assign done_pulse = (state_reg == grcr_pkg::GRCR_T_RUN) && (cnt_reg == '0);
    assign done       = (state_reg == grcr_pkg::GRCR_T_DONE);

    // Abort has priority so a dropped upstream condition cancels a pending start.
    always_ff @(posedge aclk) begin
        if (!aresetn || abort) begin
            state_reg <= grcr_pkg::GRCR_T_IDLE;
            cnt_reg   <= '0;
        end else begin
            unique case (state_reg)
                grcr_pkg::GRCR_T_IDLE: begin
                    if (start) begin
                        cnt_reg   <= grcr_span(code, unit_cycles, base_cycles);
                        state_reg <= grcr_pkg::GRCR_T_RUN;
                    end
                end
                grcr_pkg::GRCR_T_RUN: begin
                    if (cnt_reg == '0) begin
                        state_reg <= grcr_pkg::GRCR_T_DONE;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                grcr_pkg::GRCR_T_DONE: begin
                    if (start) begin
                        cnt_reg   <= grcr_span(code, unit_cycles, base_cycles);
                        state_reg <= grcr_pkg::GRCR_T_RUN;
                    end
                end
                default: begin
                    state_reg <= grcr_pkg::GRCR_T_IDLE;
                end
            endcase
        end
    end

endmodule // grcr_step_timer

// ---- tb/grcr_regs_tb.sv ----
`timescale 1ns/100ps
module grcr_regs_tb;
    localparam int STEP = 4;
    localparam int SSB  = 2;
    // Clock and reset
    logic        aclk = 1'b0;
    logic        aresetn;
    // Register bus
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    // Sequencing and settings
    logic        panel_reset_pin;
    logic [3:0]  source_boost_delay_code;
    logic        source_boost_rail_en, neg_pump_en, neg_pump_softstart_done;
    grcr_pkg::grcr_rail_cfg_t rail_cfg;
    // Bench state
    logic [33:0] wq[$];
    logic [33:0] rq[$];
    logic [3:0]  fld[4];
    logic [31:0] rnd = 32'h6147;
    int          mismatches = 0;
    int          check_count = 0;

    always #12.5 aclk = ~aclk;

    grcr_regs #(.STEP_CYCLES(STEP), .SS_BASE_CYCLES(SSB)) i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .panel_reset_pin(panel_reset_pin), .source_boost_delay_code(source_boost_delay_code),
        .source_boost_rail_en(source_boost_rail_en), .neg_pump_en(neg_pump_en),
        .neg_pump_softstart_done(neg_pump_softstart_done), .rail_cfg(rail_cfg));

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic [7:0] addr_of(input int i);
        logic [7:0] idx[4];
        idx = '{grcr_pkg::NEG_PUMP_LEVEL_IDX, grcr_pkg::NEG_PUMP_SOFTSTART_TIME_IDX,
                grcr_pkg::NEG_PUMP_START_DELAY_IDX, grcr_pkg::GATE_HIGH_BOOST_LEVEL_IDX};
        return {idx[i][5:0], 2'h0};
    endfunction

    function automatic logic sig(input int k);
        logic [2:0] s;
        s = {neg_pump_softstart_done, neg_pump_en, source_boost_rail_en};
        return s[k];
    endfunction

    task automatic compare(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic timeout();
        mismatches++;
        $display("MISMATCH at %0t: wait expired, got %h expected %h", $time, 1'h0, 1'h1);
        give_verdict();
    endtask

    // Results are compared in the edge where they are handed over.
    always @(posedge aclk) begin
        if (aresetn && s_axi_bvalid && s_axi_bready) begin
            compare({s_axi_bresp, 32'h0}, wq.size() > 0 ? wq.pop_front() : 34'h3FFFFFFFF);
        end
        if (aresetn && s_axi_rvalid && s_axi_rready) begin
            compare({s_axi_rresp, s_axi_rdata}, rq.size() > 0 ? rq.pop_front() : 34'h3FFFFFFFF);
        end
    end

    // Handshakes are judged at the falling edge, where they are settled for the next rise.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        logic fa, fw, fb;
        int   n;
        wq.push_back({er, 32'h0});
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        fb = 1'b0;
        n = 0;
        while (!fb && n < 50) begin
            @(negedge aclk);
            fa = s_axi_awvalid && s_axi_awready;
            fw = s_axi_wvalid && s_axi_wready;
            fb = s_axi_bvalid && s_axi_bready;
            n++;
            @(posedge aclk);
            if (fa) s_axi_awvalid <= 1'b0;
            if (fw) s_axi_wvalid <= 1'b0;
        end
        if (!fb) timeout();
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [33:0] er);
        logic fa, fd;
        int   n;
        rq.push_back(er);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        fd = 1'b0;
        n = 0;
        while (!fd && n < 50) begin
            @(negedge aclk);
            fa = s_axi_arvalid && s_axi_arready;
            fd = s_axi_rvalid && s_axi_rready;
            n++;
            @(posedge aclk);
            if (fa) s_axi_arvalid <= 1'b0;
        end
        if (!fd) timeout();
    endtask

    task automatic count_to(input int k, input int exp);
        int n;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (!sig(k) && n < 1000);
        if (!sig(k)) timeout();
        compare(34'(n), 34'(exp));
    endtask

    initial begin
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = '0;
        panel_reset_pin = 1'b0;
        source_boost_delay_code = 4'h0;
        fld = '{grcr_pkg::NEG_PUMP_LEVEL_RST, grcr_pkg::NEG_PUMP_SOFTSTART_TIME_RST,
                grcr_pkg::NEG_PUMP_START_DELAY_RST, grcr_pkg::GATE_HIGH_BOOST_LEVEL_RST};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        s_axi_bready <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 4; i++) begin
            axi_read(addr_of(i), {grcr_pkg::RESP_OKAY, 28'h0, fld[i]});
        end
        // Every code in every register, with random junk in the dead upper bits.
        for (int i = 0; i < 4; i++) begin
            for (int c = 0; c < 16; c++) begin
                rnd = lfsr_next(rnd);
                fld[i] = 4'(c);
                axi_write(addr_of(i), {rnd[31:4], 4'(c)}, 4'hF, grcr_pkg::RESP_OKAY);
                compare({18'h0, rail_cfg}, {18'h0, fld[0], fld[1], fld[2], fld[3]});
                axi_read(addr_of(i), {grcr_pkg::RESP_OKAY, 28'h0, 4'(c)});
            end
        end
        axi_write(addr_of(3), 32'h0000000A, 4'h0, grcr_pkg::RESP_OKAY);
        axi_read(addr_of(3), {grcr_pkg::RESP_OKAY, 28'h0, fld[3]});
        foreach (fld[j]) begin
            axi_write(j == 0 ? 8'h18 : j == 1 ? 8'h1D : 8'h2C, 32'hFFFFFFFF, 4'hF,
                      grcr_pkg::RESP_SLVERR);
            axi_read(j == 0 ? 8'h18 : j == 1 ? 8'h1D : 8'h2C, {grcr_pkg::RESP_SLVERR, 32'h0});
            compare({18'h0, rail_cfg}, {18'h0, fld[0], fld[1], fld[2], fld[3]});
        end
        // Power-up order: source rail, then negative pump, then its soft-start.
        axi_write(addr_of(2), 32'h00000002, 4'hF, grcr_pkg::RESP_OKAY);
        axi_write(addr_of(1), 32'h00000000, 4'hF, grcr_pkg::RESP_OKAY);
        source_boost_delay_code <= 4'h1;
        panel_reset_pin <= 1'b1;
        count_to(0, 5 + STEP);
        count_to(1, 2 * STEP + 1);
        count_to(2, SSB + 1);
        @(posedge aclk);
        panel_reset_pin <= 1'b0;
        repeat (6) @(negedge aclk);
        compare({31'h0, source_boost_rail_en, neg_pump_en, neg_pump_softstart_done}, 34'h0);
        give_verdict();
    end

    initial begin
        repeat (100000) @(posedge aclk);
        timeout();
    end
endmodule // grcr_regs_tb
